// ==== src/flash_host_ctrl.sv ====
// Host-side sequencer issuing protection, suspend, OTP and power commands to a serial flash
`timescale 1ns/1ps
`include "flash_cmd_defs.svh"
module flash_host_ctrl (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire logic                    cmdValid,
  output logic                         cmdReady,
  input  wire logic [7:0]              cmdCode,
  input  wire logic                    cmdPair,
  input  wire logic [31:0]             cmdAddr,
  input  wire logic [15:0]             cmdLen,
  input  wire logic [4:0]              dummyCfg,
  input  wire logic                    setProtoValid,
  input  wire flash_cmd_pkg::proto_type setProto,
  output flash_cmd_pkg::proto_type     protoNow,
  input  wire logic                    wrValid,
  output logic                         wrReady,
  input  wire logic [7:0]              wrData,
  output logic                         rdValid,
  output logic [7:0]                   rdData,
  output logic                         cmdDone,
  output logic                         cmdError,
  output logic                         csN,
  output logic                         sck,
  output logic [3:0]                   dqOut,
  output logic [3:0]                   dqOeN,
  input  wire logic [3:0]              dqIn
);
  import flash_cmd_pkg::*;

  localparam logic [7:0] DeselGap = 8'(`CS_DESEL_CYCLES);

  shift_if      link ();
  ctrl_reg_type q;
  ctrl_reg_type n;
  cmd_attr_type info;

  function automatic cmd_attr_type cmd_info(input logic [7:0] code, input proto_type p,
                                            input logic pair, input logic [4:0] cfg);
    cmd_attr_type a;
    a           = '0;
    a.ok        = 1'b1;
    a.addrLines = p;
    a.dataLines = p;
    case (code)
      `CMD_BULK_ERASE, `CMD_BULK_ERASE_ALT: begin
        a.wren = 1'b1;
      end
      `CMD_SUSPEND, `CMD_RESUME: begin
        a.ok = 1'b1;
      end
      `CMD_OTP_READ: begin
        a.addrBytes = `ADDR_BYTES_SHORT;
        a.dir       = DIR_RD;
        if (cfg != 5'h00) begin
          a.dummy = cfg;
        end else begin
          a.dummy = (p == PROTO_QUAD) ? `DUMMY_OTP_QUAD : `DUMMY_OTP_STD;
        end
      end
      `CMD_OTP_PROG: begin
        a.addrBytes = `ADDR_BYTES_SHORT;
        a.dir       = DIR_WR;
        a.wren      = 1'b1;
      end
      `CMD_QUAD_ENTER, `CMD_QUAD_EXIT, `CMD_DPD_ENTER, `CMD_DPD_EXIT: begin
        a.ok = 1'b1;
      end
      `CMD_PROT_READ: begin
        a.dir = DIR_RD;
      end
      `CMD_PROT_PROG: begin
        a.dir  = DIR_WR;
        a.wren = 1'b1;
      end
      `CMD_VLOCK_READ: begin
        a.addrBytes = `ADDR_BYTES_SHORT;
        a.dir       = DIR_RD;
      end
      `CMD_VLOCK_WRITE: begin
        a.addrBytes = `ADDR_BYTES_SHORT;
        a.dir       = DIR_WR;
        a.wren      = 1'b1;
      end
      `CMD_NVLOCK_READ: begin
        a.addrBytes = `ADDR_BYTES_LONG;
        a.dir       = DIR_RD;
      end
      `CMD_NVLOCK_WRITE: begin
        a.addrBytes = `ADDR_BYTES_LONG;
        a.wren      = 1'b1;
      end
      `CMD_NVLOCK_ERASE, `CMD_FREEZE_SET: begin
        a.wren = 1'b1;
      end
      `CMD_FREEZE_READ, `CMD_PWD_READ: begin
        a.dir = DIR_RD;
        a.ok  = (p == PROTO_SINGLE);
      end
      `CMD_PWD_WRITE: begin
        a.dir  = DIR_WR;
        a.wren = 1'b1;
      end
      `CMD_PWD_UNLOCK: begin
        a.dir = DIR_WR;
      end
      `CMD_IFACE_ACT: begin
        a.pair = pair;
        a.dir  = pair ? DIR_WR : DIR_NONE;
      end
      `CMD_SFDP_READ: begin
        a.addrBytes = `ADDR_BYTES_SHORT;
        a.dummy     = `DUMMY_FIXED;
        a.dir       = DIR_RD;
      end
      `CMD_GPRR_READ: begin
        a.dummy = `DUMMY_FIXED;
        a.dir   = DIR_RD;
      end
      default: begin
        a.ok = 1'b0;
      end
    endcase
    return a;
  endfunction : cmd_info

  // Phase that follows the code bytes, skipping empty ones
  function automatic ctrl_state_type after_code(input cmd_attr_type a);
    if (a.addrBytes != 3'h0) begin
      return ST_ADDR;
    end else if (a.dummy != 5'h00) begin
      return ST_DUMMY;
    end else if (a.dir != DIR_NONE) begin
      return ST_DATA;
    end
    return ST_DESEL;
  endfunction : after_code

  always_comb begin
    info        = cmd_info(cmdCode, q.proto, cmdPair, dummyCfg);
    n           = q;
    n.rdValid   = 1'b0;
    n.cmdDone   = 1'b0;
    n.cmdError  = 1'b0;
    link.start  = 1'b0;
    link.op     = OP_TX;
    link.lines  = q.proto;
    link.count  = 8'h00;
    link.txByte = q.code;
    wrReady     = 1'b0;
    cmdReady    = (q.st == ST_IDLE);
    case (q.st)
      ST_IDLE: begin
        if (setProtoValid) begin
          n.proto = setProto;
        end else if (cmdValid) begin
          if (!info.ok) begin
            n.cmdError = 1'b1;
          end else begin
            n.attr     = info;
            n.code     = cmdCode;
            n.len      = cmdLen;
            n.addrLeft = info.addrBytes;
            n.addr     = (info.addrBytes == `ADDR_BYTES_LONG) ? cmdAddr : {cmdAddr[23:0], 8'h00};
            n.csN      = 1'b0;
            n.issued   = 1'b0;
            n.st       = info.wren ? ST_WREN : ST_CMD;
          end
        end
      end
      ST_WREN: begin
        link.txByte = `CMD_WRITE_ENABLE;
        link.start  = !q.issued;
        n.issued    = 1'b1;
        if (link.done) begin
          n.csN    = 1'b1;
          n.gap    = DeselGap;
          n.issued = 1'b0;
          n.st     = ST_WGAP;
        end
      end
      ST_WGAP: begin
        // Write enable only latches once select rises, so a real gap is kept
        n.gap = q.gap - 8'h01;
        if (q.gap == 8'h01) begin
          n.csN = 1'b0;
          n.st  = ST_CMD;
        end
      end
      ST_CMD, ST_CODE2: begin
        link.txByte = (q.st == ST_CODE2) ? `CMD_CRC_SECOND : q.code;
        link.start  = !q.issued;
        n.issued    = 1'b1;
        if (link.done) begin
          n.issued = 1'b0;
          n.st     = (q.st == ST_CMD && q.attr.pair) ? ST_CODE2 : after_code(q.attr);
        end
      end
      ST_ADDR: begin
        link.lines  = q.attr.addrLines;
        link.txByte = q.addr[31:24];
        link.start  = !q.issued;
        n.issued    = 1'b1;
        if (link.done) begin
          n.issued   = 1'b0;
          n.addr     = {q.addr[23:0], 8'h00};
          n.addrLeft = q.addrLeft - 3'h1;
          if (q.addrLeft == 3'h1) begin
            n.st = (q.attr.dummy != 5'h00) ? ST_DUMMY
                 : (q.attr.dir != DIR_NONE) ? ST_DATA : ST_DESEL;
          end
        end
      end
      ST_DUMMY: begin
        link.op    = OP_DUMMY;
        link.lines = q.attr.dataLines;
        link.count = {3'h0, q.attr.dummy};
        link.start = !q.issued;
        n.issued   = 1'b1;
        if (link.done) begin
          n.issued = 1'b0;
          n.st     = (q.attr.dir != DIR_NONE) ? ST_DATA : ST_DESEL;
        end
      end
      ST_DATA: begin
        link.lines  = q.attr.dataLines;
        link.op     = (q.attr.dir == DIR_RD) ? OP_RX : OP_TX;
        link.txByte = wrData;
        if (q.len == 16'h0000) begin
          n.st = ST_DESEL;
        end else if (!q.issued) begin
          // Writes stall with select low until the user offers a byte
          link.start = (q.attr.dir == DIR_RD) || wrValid;
          wrReady    = (q.attr.dir == DIR_WR) && wrValid;
          n.issued   = link.start;
        end else if (link.done) begin
          n.issued = 1'b0;
          n.len    = q.len - 16'h0001;
          if (q.attr.dir == DIR_RD) begin
            n.rdData  = link.rxByte;
            n.rdValid = 1'b1;
          end
        end
      end
      ST_DESEL: begin
        if (!q.csN) begin
          n.csN = 1'b1;
          n.gap = DeselGap;
        end else begin
          n.gap = q.gap - 8'h01;
          if (q.gap == 8'h01) begin
            n.st      = ST_IDLE;
            n.cmdDone = 1'b1;
            if (q.code == `CMD_QUAD_ENTER) begin
              n.proto = PROTO_QUAD;
            end else if (q.code == `CMD_QUAD_EXIT) begin
              n.proto = PROTO_SINGLE;
            end
          end
        end
      end
      default: begin
        n.st  = ST_IDLE;
        n.csN = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{st: ST_IDLE, csN: 1'b1, proto: PROTO_SINGLE, default: '0};
    end else if (ce) begin
      q <= n;
    end
  end

  serial_shifter shifter (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .sh    (link.shifter),
    .sck   (sck),
    .dqOut (dqOut),
    .dqOeN (dqOeN),
    .dqIn  (dqIn)
  );

  assign csN      = q.csN;
  assign protoNow = q.proto;
  assign rdValid  = q.rdValid;
  assign rdData   = q.rdData;
  assign cmdDone  = q.cmdDone;
  assign cmdError = q.cmdError;
endmodule : flash_host_ctrl

// ==== include/flash_cmd_defs.svh ====
// Command codes, phase figures and timing counts of the flash host controller
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

`define CMD_WRITE_ENABLE   8'h06
`define CMD_BULK_ERASE     8'hc7
`define CMD_BULK_ERASE_ALT 8'h60
`define CMD_SUSPEND        8'h75
`define CMD_RESUME         8'h7a
`define CMD_OTP_READ       8'h4b
`define CMD_OTP_PROG       8'h42
`define CMD_QUAD_ENTER     8'h35
`define CMD_QUAD_EXIT      8'hf5
`define CMD_DPD_ENTER      8'hb9
`define CMD_DPD_EXIT       8'hab
`define CMD_PROT_READ      8'h2d
`define CMD_PROT_PROG      8'h2c
`define CMD_VLOCK_READ     8'he8
`define CMD_VLOCK_WRITE    8'he5
`define CMD_NVLOCK_READ    8'he2
`define CMD_NVLOCK_WRITE   8'he3
`define CMD_NVLOCK_ERASE   8'he4
`define CMD_FREEZE_READ    8'ha7
`define CMD_FREEZE_SET     8'ha6
`define CMD_PWD_READ       8'h27
`define CMD_PWD_WRITE      8'h28
`define CMD_PWD_UNLOCK     8'h29
`define CMD_IFACE_ACT      8'h9b
`define CMD_CRC_SECOND     8'h27
`define CMD_SFDP_READ      8'h5a
`define CMD_GPRR_READ      8'h96

`define ADDR_BYTES_SHORT   3'h3
`define ADDR_BYTES_LONG    3'h4
`define DUMMY_OTP_STD      5'h08
`define DUMMY_OTP_QUAD     5'h0a
`define DUMMY_FIXED        5'h08

`define CLK_PERIOD_NS      100
`define SCK_PERIOD_NS      800
`define SCK_HALF_CYCLES    ((`SCK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_DESEL_NS        50
`define CS_DESEL_CYCLES    ((`CS_DESEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== include/flash_cmd_pkg.sv ====
// Types shared by the flash host controller and its serial shifter
package flash_cmd_pkg;

  typedef enum logic [1:0] {
    PROTO_SINGLE = 2'h0,
    PROTO_DUAL   = 2'h1,
    PROTO_QUAD   = 2'h2
  } proto_type;

  typedef enum logic [1:0] {
    OP_TX    = 2'h0,
    OP_RX    = 2'h1,
    OP_DUMMY = 2'h2
  } shift_op_type;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_RD   = 2'h1,
    DIR_WR   = 2'h2
  } dir_type;

  typedef struct packed {
    logic      ok;
    logic      wren;
    logic      pair;
    logic [2:0] addrBytes;
    logic [4:0] dummy;
    dir_type   dir;
    proto_type addrLines;
    proto_type dataLines;
  } cmd_attr_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_WREN  = 4'h1,
    ST_WGAP  = 4'h3,
    ST_CMD   = 4'h2,
    ST_CODE2 = 4'h6,
    ST_ADDR  = 4'h7,
    ST_DUMMY = 4'h5,
    ST_DATA  = 4'h4,
    ST_DESEL = 4'hc
  } ctrl_state_type;

  typedef struct packed {
    logic         busy;
    logic         sck;
    logic [2:0]   half;
    logic [7:0]   clocks;
    logic [7:0]   sh;
    shift_op_type op;
    proto_type    lines;
    logic [3:0]   meta;
    logic [3:0]   sync;
    logic         done;
    logic [3:0]   out;
    logic [3:0]   oeN;
  } shifter_reg_type;

  typedef struct packed {
    ctrl_state_type st;
    logic           csN;
    proto_type      proto;
    cmd_attr_type   attr;
    logic [7:0]     code;
    logic [31:0]    addr;
    logic [2:0]     addrLeft;
    logic [15:0]    len;
    logic           issued;
    logic [7:0]     gap;
    logic [7:0]     rdData;
    logic           rdValid;
    logic           cmdDone;
    logic           cmdError;
  } ctrl_reg_type;

endpackage : flash_cmd_pkg

// ==== include/shift_if.sv ====
// Byte and dummy-cycle request channel between sequencer and shifter
`timescale 1ns/1ps
interface shift_if;
  import flash_cmd_pkg::*;
  logic         start;
  shift_op_type op;
  proto_type    lines;
  logic [7:0]   count;
  logic [7:0]   txByte;
  logic         done;
  logic [7:0]   rxByte;

  modport sequencer (output start, output op, output lines, output count, output txByte,
                     input done, input rxByte);
  modport shifter   (input start, input op, input lines, input count, input txByte,
                     output done, output rxByte);
endinterface : shift_if

// ==== src/serial_shifter.sv ====
// Serial clock divider and one-, two- or four-line byte shifter
`timescale 1ns/1ps
`include "flash_cmd_defs.svh"
module serial_shifter (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  ce,
  shift_if.shifter   sh,
  output logic       sck,
  output logic [3:0] dqOut,
  output logic [3:0] dqOeN,
  input  wire logic [3:0] dqIn
);
  import flash_cmd_pkg::*;

  localparam logic [2:0] HalfLast = 3'(`SCK_HALF_CYCLES - 1);

  shifter_reg_type q;
  shifter_reg_type n;

  always_comb begin
    n      = q;
    n.done = 1'b0;
    n.meta = dqIn;
    n.sync = q.meta;
    if (!q.busy) begin
      // Idle lines follow the live protocol so quad releases its pins at once
      n.lines = sh.lines;
      if (sh.start) begin
        n.busy  = 1'b1;
        n.op    = sh.op;
        n.sh    = sh.txByte;
        n.half  = 3'h0;
        n.sck   = 1'b0;
        if (sh.op == OP_DUMMY) begin
          n.clocks = sh.count;
        end else begin
          case (sh.lines)
            PROTO_DUAL: n.clocks = 8'h04;
            PROTO_QUAD: n.clocks = 8'h02;
            default:    n.clocks = 8'h08;
          endcase
        end
      end
    end else if (q.half == HalfLast) begin
      n.half = 3'h0;
      if (!q.sck) begin
        n.sck = 1'b1;
      end else begin
        // Sample just before the falling edge: the synced copy lags two cycles
        n.sck = 1'b0;
        case (q.lines)
          PROTO_DUAL: n.sh = {q.sh[5:0], q.sync[1:0]};
          PROTO_QUAD: n.sh = {q.sh[3:0], q.sync[3:0]};
          default:    n.sh = {q.sh[6:0], q.sync[1]};
        endcase
        n.clocks = q.clocks - 8'h01;
        if (q.clocks == 8'h01) begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end
    end else begin
      n.half = q.half + 3'h1;
    end
    // Hold and write-protect lines stay high outside quad
    n.out = 4'b1100;
    n.oeN = 4'b0000;
    if (n.lines == PROTO_QUAD) begin
      n.oeN = 4'b1111;
    end
    if (n.busy && n.op == OP_TX) begin
      case (n.lines)
        PROTO_DUAL: n.out[1:0] = n.sh[7:6];
        PROTO_QUAD: n.out      = n.sh[7:4];
        default:    n.out[0]   = n.sh[7];
      endcase
      if (n.lines == PROTO_QUAD) begin
        n.oeN = 4'b0000;
      end
      if (n.lines == PROTO_SINGLE) begin
        n.oeN[1] = 1'b1;
      end
    end else begin
      n.oeN[1:0] = 2'b11;
      if (!n.busy && n.lines == PROTO_SINGLE) begin
        n.oeN[0] = 1'b0;
        n.out[0] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{op: OP_TX, lines: PROTO_SINGLE, out: 4'b1100, oeN: 4'b0011, default: '0};
    end else if (ce) begin
      q <= n;
    end
  end

  assign sh.done   = q.done;
  assign sh.rxByte = q.sh;
  assign sck       = q.sck;
  assign dqOut     = q.out;
  assign dqOeN     = q.oeN;
endmodule : serial_shifter

// ==== sim/flash_host_ctrl_sva.sv ====
// Port-level checks on the flash host controller
`timescale 1ns/1ps
module flash_host_ctrl_sva
  import flash_cmd_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      ce,
  input wire logic                      cmdValid,
  input wire logic                      cmdReady,
  input wire logic                      setProtoValid,
  input wire flash_cmd_pkg::proto_type  protoNow,
  input wire logic                      wrValid,
  input wire logic                      wrReady,
  input wire logic                      rdValid,
  input wire logic                      cmdDone,
  input wire logic                      cmdError,
  input wire logic                      csN,
  input wire logic                      sck,
  input wire logic [3:0]                dqOut,
  input wire logic [3:0]                dqOeN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_reset_idle: assert property (
    $fell(reset) |-> csN && !sck && dqOut == 4'hc && dqOeN == 4'h3 && protoNow == PROTO_SINGLE)
    else $error("idle pin state wrong after reset");
  chk_sck_still: assert property (
    csN |-> !sck) else $error("serial clock moves while deselected");
  chk_sck_high: assert property (
    $rose(sck) |-> sck [*4] ##1 !sck) else $error("serial clock high phase not 4 cycles");
  chk_sck_low: assert property (
    $fell(sck) |-> !sck [*3]) else $error("serial clock low phase too short");
  chk_take_select: assert property (
    cmdValid && cmdReady && ce && !setProtoValid |=> !csN || cmdError)
    else $error("taken request neither selects nor errors");
  chk_error_quiet: assert property (
    cmdError |-> csN ##1 csN && cmdReady) else $error("refused request touched the pins");
  chk_busy_ready: assert property (
    !csN |-> !cmdReady) else $error("ready while a frame is open");
  chk_done_gap: assert property (
    cmdDone |-> csN && $past(csN) ##1 !cmdDone) else $error("done without deselect gap");
  chk_freeze_hold: assert property (
    !ce |=> $stable(csN) && $stable(sck) && $stable(dqOut)) else $error("pins move while frozen");
  chk_single_lines: assert property (
    protoNow == PROTO_SINGLE && !csN |-> dqOeN[3:1] == 3'b001 && dqOut[3:2] == 2'b11)
    else $error("single protocol line use wrong");
  chk_quad_release: assert property (
    protoNow == PROTO_QUAD && $stable(protoNow) && csN && $past(csN) |-> dqOeN == 4'hf)
    else $error("quad lines not released when idle");
  chk_rd_pulse: assert property (
    rdValid |=> !rdValid) else $error("read strobe longer than one cycle");
  chk_wr_take: assert property (
    wrReady |-> wrValid && !csN) else $error("write byte taken outside a frame");
  chk_proto_cause: assert property (
    $changed(protoNow) |-> $past(setProtoValid) || $past(cmdDone) || cmdDone or ##[1:3] cmdDone)
    else $error("protocol changed without cause");
endmodule : flash_host_ctrl_sva

bind flash_host_ctrl flash_host_ctrl_sva u_sva (
  .clk(clk), .reset(reset), .ce(ce), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .setProtoValid(setProtoValid), .protoNow(protoNow), .wrValid(wrValid), .wrReady(wrReady),
  .rdValid(rdValid), .cmdDone(cmdDone), .cmdError(cmdError), .csN(csN), .sck(sck),
  .dqOut(dqOut), .dqOeN(dqOeN)
);

// ==== sim/flash_dev_model.sv ====
// Behavioural serial flash device facing the host controller
`timescale 1ns/1ps
module flash_dev_model (
  input  wire logic       clk,
  input  wire logic       csN,
  input  wire logic       sck,
  input  wire logic [3:0] dqOut,
  input  wire logic [3:0] dqOeN,
  output logic [3:0]      dqIn,
  output logic            frameTick,
  output logic [7:0]      frameCode,
  output logic [7:0]      frameEdges,
  output logic [7:0]      frameLast
);
  localparam logic [7:0] PAT = 8'hb4;
  logic [7:0] sr = 8'h00;
  logic [7:0] code = 8'h00;
  logic [15:0] edges = 16'h0000;
  logic [15:0] falls = 16'h0000;
  logic       quad = 1'b0;
  logic       wel = 1'b0;
  logic       held = 1'b0;
  logic       asleep = 1'b0;
  logic       tog = 1'b0;
  logic [3:0] drv;

  initial frameTick = 1'b0;
  always @(posedge clk) tog <= ~tog;
  always @(negedge csN) begin
    edges = 16'h0000;
    falls = 16'h0000;
  end
  always @(posedge sck) begin
    if (!csN) begin
      sr = quad ? {sr[3:0], dqIn} : {sr[6:0], dqIn[0]};
      edges = edges + 16'h0001;
      if (edges == (quad ? 16'h0002 : 16'h0008)) code = sr;
    end
  end
  always @(negedge sck) if (!csN) falls = falls + 16'h0001;
  // Released lines toggle while deselected so a stale level never passes for data
  // Purpose register runs dry after 64 bytes and then reads as zero
  assign drv = csN ? {4{tog}}
             : (code == 8'h96 && falls >= (quad ? 16'h008a : 16'h0210)) ? 4'h0
             : quad ? (falls[0] ? PAT[3:0] : PAT[7:4])
             : {4{PAT[3'h7 - falls[2:0]]}};
  assign dqIn = (dqOut & ~dqOeN) | (drv & dqOeN);
  always @(posedge csN) begin
    if (edges != 16'h0000) begin
      frameCode = code;
      frameEdges = edges[7:0];
      frameLast = sr;
      case (code)
        8'h06: wel = 1'b1;
        8'hc7, 8'h60: wel = 1'b0;
        8'h75: held = 1'b1;
        8'h7a: held = 1'b0;
        8'h35: quad = 1'b1;
        8'hf5: quad = 1'b0;
        8'hb9: asleep = 1'b1;
        8'hab: asleep = 1'b0;
        default: ;
      endcase
      frameTick = ~frameTick;
    end
  end
endmodule : flash_dev_model

// ==== sim/tb_flash_host_ctrl.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_flash_host_ctrl;
  import flash_cmd_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] edges;
    logic [7:0] last;
    logic       care;
  } frame_type;
  localparam logic [7:0] PAT = 8'hb4;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        cmdValid = 1'b0;
  logic [7:0]  cmdCode = 8'h00;
  logic        cmdPair = 1'b0;
  logic [31:0] cmdAddr = 32'h0;
  logic [15:0] cmdLen = 16'h0;
  logic [4:0]  dummyCfg = 5'h00;
  logic        setProtoValid = 1'b0;
  proto_type   setProto = PROTO_SINGLE;
  logic        wrValid = 1'b0;
  logic [7:0]  wrData = 8'h00;
  logic        cmdReady, wrReady, rdValid, cmdDone, cmdError, csN, sck, frameTick;
  proto_type   protoNow;
  logic [7:0]  rdData, frameCode, frameEdges, frameLast;
  logic [3:0]  dqOut, dqOeN, dqIn;
  logic [31:0] seed = 32'd90;
  logic        q = 1'b0;
  int          n_fail = 0;
  int          n_compared = 0;
  frame_type   fq[$];
  frame_type   fe;
  logic [7:0]  rq[$];

  always #50 clk = ~clk;

  flash_host_ctrl u_dut (.clk(clk), .reset(reset), .ce(ce), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdPair(cmdPair), .cmdAddr(cmdAddr),
    .cmdLen(cmdLen), .dummyCfg(dummyCfg), .setProtoValid(setProtoValid), .setProto(setProto),
    .protoNow(protoNow), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdData(rdData), .cmdDone(cmdDone), .cmdError(cmdError), .csN(csN),
    .sck(sck), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));
  flash_dev_model u_dev (.clk(clk), .csN(csN), .sck(sck), .dqOut(dqOut), .dqOeN(dqOeN),
    .dqIn(dqIn), .frameTick(frameTick), .frameCode(frameCode), .frameEdges(frameEdges),
    .frameLast(frameLast));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expectations are queued before driving; the monitors below consume them
  task automatic issue(input logic [7:0] code, input logic pair, input int ab, input int dm,
                       input int len, input logic wren, input logic rd, input logic err);
    logic [7:0]  wb[$];
    logic [31:0] a;
    int          epb, s, n;
    logic        got;
    epb = q ? 2 : 8;
    a = xs();
    got = 1'b0;
    for (int i = 0; i < len; i++) wb.push_back(8'(xs()));
    s = epb * (1 + pair + ab) + dm;
    if (!err) begin
      if (wren) fq.push_back('{8'h06, 8'(epb), 8'h06, 1'b1});
      fq.push_back('{code, 8'(s + epb * len),
        rd ? 8'h00 : len > 0 ? wb[len - 1] : ab > 0 ? a[7:0] : code, !rd});
      // Pattern period is 8 bit times, so every read byte rotates alike
      if (rd) for (int i = 0; i < len; i++)
        rq.push_back(code == 8'h96 && i > 63 ? 8'h00
          : q ? PAT : 8'((PAT << (s % 8)) | (PAT >> (8 - s % 8))));
    end
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdCode = code;
    cmdPair = pair;
    cmdAddr = a;
    cmdLen = 16'(len);
    wrValid = len > 0 && !rd;
    wrData = len > 0 ? wb[0] : 8'h00;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      if (cmdReady === 1'b1 && ce === 1'b1) break;
    end
    if (n == 100) begin
      check("ready", 1, 0);
      end_sim();
    end
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(negedge clk);
      if (cmdError === 1'b1) got = 1'b1;
      if (cmdDone === 1'b1 || got) break;
      if (wrReady === 1'b1) begin
        void'(wb.pop_front());
        @(posedge clk);
        #1;
        wrData = wb.size() > 0 ? wb[0] : 8'h00;
        wrValid = wb.size() > 0;
      end
    end
    wrValid = 1'b0;
    if (n == 20000) begin
      check("timeout", 1, 0);
      end_sim();
    end
    check("error", got, err);
    if (err) check("select", csN, 1'b1);
  endtask : issue

  always @(frameTick) begin
    if (reset === 1'b0) begin
      if (fq.size() == 0) check("frame", 1, 0);
      else begin
        fe = fq.pop_front();
        check("code", frameCode, fe.code);
        check("edges", frameEdges, fe.edges);
        if (fe.care) check("last", frameLast, fe.last);
      end
    end
  end

  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      if (rq.size() == 0) check("read", 1, 0);
      else check("read", rdData, rq.pop_front());
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    issue(8'hc7, 0, 0, 0, 0, 1, 0, 0);
    issue(8'h60, 0, 0, 0, 0, 1, 0, 0);
    @(posedge clk);
    #1;
    ce = 1'b0;
    fork
      issue(8'h75, 0, 0, 0, 0, 0, 0, 0);
      begin
        repeat (5) @(posedge clk);
        #1;
        check("select", csN, 1'b1);
        ce = 1'b1;
      end
    join
    issue(8'h7a, 0, 0, 0, 0, 0, 0, 0);
    issue(8'hb9, 0, 0, 0, 0, 0, 0, 0);
    issue(8'hab, 0, 0, 0, 0, 0, 0, 0);
    issue(8'h4b, 0, 3, 8, 2, 0, 1, 0);
    issue(8'h42, 0, 3, 0, 2, 1, 0, 0);
    issue(8'h2d, 0, 0, 0, 1, 0, 1, 0);
    issue(8'h2c, 0, 0, 0, 1, 1, 0, 0);
    issue(8'he8, 0, 3, 0, 1, 0, 1, 0);
    issue(8'he5, 0, 3, 0, 1, 1, 0, 0);
    issue(8'he2, 0, 4, 0, 1, 0, 1, 0);
    issue(8'he3, 0, 4, 0, 0, 1, 0, 0);
    issue(8'he4, 0, 0, 0, 0, 1, 0, 0);
    issue(8'ha7, 0, 0, 0, 1, 0, 1, 0);
    issue(8'ha6, 0, 0, 0, 0, 1, 0, 0);
    issue(8'h27, 0, 0, 0, 1, 0, 1, 0);
    issue(8'h28, 0, 0, 0, 1, 1, 0, 0);
    issue(8'h29, 0, 0, 0, 1, 0, 0, 0);
    issue(8'h9b, 0, 0, 0, 0, 0, 0, 0);
    issue(8'h9b, 1, 0, 0, 1, 0, 0, 0);
    issue(8'h00, 0, 0, 0, 1, 0, 0, 1);
    dummyCfg = 5'h06;
    issue(8'h4b, 0, 3, 6, 1, 0, 1, 0);
    issue(8'h5a, 0, 3, 8, 1, 0, 1, 0);
    issue(8'h96, 0, 0, 8, 65, 0, 1, 0);
    dummyCfg = 5'h00;
    issue(8'h35, 0, 0, 0, 0, 0, 0, 0);
    q = 1'b1;
    issue(8'ha7, 0, 0, 0, 1, 0, 1, 1);
    issue(8'h27, 0, 0, 0, 1, 0, 1, 1);
    issue(8'h4b, 0, 3, 10, 1, 0, 1, 0);
    issue(8'h42, 0, 3, 0, 1, 1, 0, 0);
    issue(8'hf5, 0, 0, 0, 0, 0, 0, 0);
    q = 1'b0;
    @(posedge clk);
    #1;
    setProtoValid = 1'b1;
    setProto = PROTO_DUAL;
    cmdValid = 1'b1;
    cmdCode = 8'h75;
    @(posedge clk);
    #1;
    setProtoValid = 1'b0;
    cmdValid = 1'b0;
    @(negedge clk);
    check("proto", protoNow, PROTO_DUAL);
    check("select", csN, 1'b1);
    repeat (10) @(negedge clk);
    check("pending", fq.size() + rq.size(), 0);
    end_sim();
  end
endmodule : tb_flash_host_ctrl
